// >>> design/branch_bit_control_decoder.sv
/*
 Decode and execute of short relative jumps, bit-test jumps, bit set and
 clear, control instructions and long jump and call. Assumes program
 memory and data space answer combinationally to registered addresses,
 and that the core handles every other opcode through the other_op
 handshake.
*/
`timescale 1ns/1ps
module branch_bit_control_decoder (
   input wire logic clk,
   input wire logic sys_rst,
   output logic [11:0] prog_addr,
   input wire logic [7:0] prog_data,
   output logic [7:0] ds_addr,
   input wire logic [7:0] ds_rdata,
   output logic [7:0] ds_wdata,
   output logic ds_we,
   input wire logic watchdog_pin,
   input wire logic saved_z,
   input wire logic saved_c,
   input wire logic wake,
   output logic other_op,
   input wire logic other_done,
   input wire logic [11:0] other_pc,
   output logic stop_req,
   output logic wait_req,
   output logic instr_done,
   output logic flag_z,
   output logic flag_c,
   output logic [11:0] pc
);

   // ----------------------------------------------------------------
   // state and decode
   // ----------------------------------------------------------------
   branch_bit_pkg::state_e st_q;
   branch_bit_pkg::op_class_e cls;
   logic [2:0] cyc_q, ncyc, bit_idx;
   logic [11:0] pc_q, fetch_q, next_pc;
   logic [7:0] op_q, b1_q, b2_q, wbyte;
   logic z_q, c_q, tbit_q, tbit, wd_m_q, wd_q;
   logic start, last, short_taken, bt_taken;
   logic [7:0] op;
   localparam int STACK_DEPTH_L = branch_bit_pkg::STACK_DEPTH;
   logic [11:0] stk [STACK_DEPTH_L];
   logic [1:0] sp_q;

   // the opcode is live on the bus in its first cycle, latched after
   assign start = (st_q == branch_bit_pkg::ST_RUN) && (cyc_q == 3'h0);
   assign op = start ? prog_data : op_q;
   assign last = (st_q == branch_bit_pkg::ST_RUN) &&
                 (cls != branch_bit_pkg::C_OTHER) &&
                 (cyc_q == ncyc - 3'h1);

   opcode_classify u_cls (
      .opcode(op),
      .cls(cls),
      .ncyc(ncyc),
      .bit_idx(bit_idx)
   );

   // modified byte is built from the byte as read in cycle 2
   bit_unit u_bit (
      .byte_in(ds_rdata),
      .bit_idx(bit_idx),
      .set_bit(op_q[4]),
      .byte_out(wbyte),
      .bit_val(tbit)
   );

   // ----------------------------------------------------------------
   // branch conditions and next address
   // ----------------------------------------------------------------
   // nibble bit 1 picks carry or zero, bit 2 the wanted level
   assign short_taken = op_q[1] ? (c_q == op_q[2]) : (z_q == op_q[2]);
   assign bt_taken = (tbit_q == op_q[4]);

   always_comb begin
      next_pc = pc_q + branch_bit_pkg::STEP_1;
      case (cls)
         branch_bit_pkg::C_SHORT:
            if (short_taken) begin
               // 5-bit displacement from the opcode's successor
               next_pc = pc_q + branch_bit_pkg::STEP_1 +
                         {{7{op_q[7]}}, op_q[7:3]};
            end
         branch_bit_pkg::C_BT:
            if (bt_taken) begin
               next_pc = pc_q + branch_bit_pkg::STEP_2 +
                         {{4{b2_q[7]}}, b2_q};
            end else begin
               next_pc = pc_q + branch_bit_pkg::STEP_3;
            end
         branch_bit_pkg::C_BIT:
            next_pc = pc_q + branch_bit_pkg::STEP_2;
         branch_bit_pkg::C_LONG,
         branch_bit_pkg::C_CALL:
            next_pc = {op_q[7:4], b1_q};
         branch_bit_pkg::C_RET,
         branch_bit_pkg::C_INTERRUPT_RETURN:
            next_pc = stk[sp_q - 2'h1];
         default:
            next_pc = pc_q + branch_bit_pkg::STEP_1;
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // cycle counter pads every instruction except foreign opcodes to its documented length
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= branch_bit_pkg::ST_RUN;
         cyc_q <= 3'h0;
      end else begin
         case (st_q)
            branch_bit_pkg::ST_RUN:
               if (start && cls == branch_bit_pkg::C_OTHER) begin
                  st_q <= branch_bit_pkg::ST_OTHER;
               end else if (last) begin
                  cyc_q <= 3'h0;
                  if (cls == branch_bit_pkg::C_STOP || cls == branch_bit_pkg::C_WAIT) begin
                     st_q <= branch_bit_pkg::ST_SLEEP;
                  end
               end else begin
                  cyc_q <= cyc_q + 3'h1;
               end
            branch_bit_pkg::ST_SLEEP:
               if (wake) begin
                  st_q <= branch_bit_pkg::ST_RUN;
               end
            branch_bit_pkg::ST_OTHER:
               if (other_done) begin
                  st_q <= branch_bit_pkg::ST_RUN;
               end
            default:
               st_q <= branch_bit_pkg::ST_RUN;
         endcase
      end
   end

   // program counter and registered fetch address
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_q <= branch_bit_pkg::PC_RESET;
         fetch_q <= branch_bit_pkg::PC_RESET;
      end else if (st_q == branch_bit_pkg::ST_OTHER && other_done) begin
         pc_q <= other_pc;
         fetch_q <= other_pc;
      end else if (last) begin
         pc_q <= next_pc;
         fetch_q <= next_pc;
      end else if (start) begin
         fetch_q <= pc_q + branch_bit_pkg::STEP_1;
      end else if (st_q == branch_bit_pkg::ST_RUN && cyc_q == 3'h1) begin
         fetch_q <= pc_q + branch_bit_pkg::STEP_2;
      end
   end

   // operand bytes; the byte after the opcode addresses data
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         op_q <= branch_bit_pkg::OP_NOP;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         tbit_q <= 1'b0;
      end else if (start) begin
         op_q <= prog_data;
      end else if (cyc_q == 3'h1) begin
         b1_q <= prog_data;
      end else if (cyc_q == 3'h2) begin
         b2_q <= prog_data; // bit_branch_offset byte
         tbit_q <= tbit;
      end
   end

   // data space access: read in cycle 2, write back in cycle 3
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ds_addr <= 8'h00;
         ds_wdata <= 8'h00;
         ds_we <= 1'b0;
      end else begin
         ds_we <= 1'b0;
         if (st_q == branch_bit_pkg::ST_RUN && cyc_q == 3'h1) begin
            ds_addr <= prog_data;
         end
         if (st_q == branch_bit_pkg::ST_RUN && cyc_q == 3'h2 &&
             cls == branch_bit_pkg::C_BIT) begin
            ds_wdata <= wbyte;
            ds_we <= 1'b1;
         end
      end
   end

   // flags: only bit-test jumps and interrupt_return touch them
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         z_q <= 1'b0;
         c_q <= 1'b0;
      end else if (last && cls == branch_bit_pkg::C_BT) begin
         c_q <= tbit_q;
      end else if (last && cls == branch_bit_pkg::C_INTERRUPT_RETURN) begin
         z_q <= saved_z;
         c_q <= saved_c;
      end
   end

   // return stack; overflow wraps and overwrites the oldest entry
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sp_q <= 2'h0;
         for (int i = 0; i < STACK_DEPTH_L; i++) begin
            stk[i] <= branch_bit_pkg::PC_RESET;
         end
      end else if (last && cls == branch_bit_pkg::C_CALL) begin
         stk[sp_q] <= pc_q + branch_bit_pkg::STEP_2;
         sp_q <= sp_q + 2'h1;
      end else if (last && (cls == branch_bit_pkg::C_RET ||
                            cls == branch_bit_pkg::C_INTERRUPT_RETURN)) begin
         sp_q <= sp_q - 2'h1;
      end
   end

   // watchdog option is a pin: two flops before use
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wd_m_q <= 1'b0;
         wd_q <= 1'b0;
      end else begin
         wd_m_q <= watchdog_pin;
         wd_q <= wd_m_q;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // stop degrades to wait while the watchdog option is set, so the watchdog can never be frozen
   assign stop_req = last && cls == branch_bit_pkg::C_STOP && !wd_q;
   assign wait_req = last && (cls == branch_bit_pkg::C_WAIT ||
                              (cls == branch_bit_pkg::C_STOP && wd_q));
   assign other_op = start && cls == branch_bit_pkg::C_OTHER;
   assign instr_done = last;
   assign prog_addr = fetch_q;
   assign flag_z = z_q;
   assign flag_c = c_q;
   assign pc = pc_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_short_go;
      start && cls == branch_bit_pkg::C_SHORT;
   endsequence
   sequence s_bt_go;
      start && cls == branch_bit_pkg::C_BT;
   endsequence
   sequence s_bit_go;
      start && cls == branch_bit_pkg::C_BIT;
   endsequence

   property p_short_len;
      s_short_go |-> !last ##1 (last && $stable(z_q) && $stable(c_q))
                     ##1 ($stable(z_q) && $stable(c_q));
   endproperty
   a_short_len: assert property (p_short_len)
      else $error("short jump length or flags wrong");

   property p_short_seq;
      last && cls == branch_bit_pkg::C_SHORT && !short_taken
         |=> pc_q == $past(pc_q) + 12'h001;
   endproperty
   a_short_seq: assert property (p_short_seq)
      else $error("untaken short jump not sequential");

   property p_short_range;
      last && cls == branch_bit_pkg::C_SHORT && short_taken
         |=> ($signed(pc_q - $past(pc_q)) >= -12'sd15) &&
             ($signed(pc_q - $past(pc_q)) <= 12'sd16);
   endproperty
   a_short_range: assert property (p_short_range)
      else $error("short jump target out of range");

   property p_bt_len;
      s_bt_go |-> (!last) [*4] ##1 last;
   endproperty
   a_bt_len: assert property (p_bt_len)
      else $error("bit-test jump not five cycles");

   property p_bt_carry;
      last && cls == branch_bit_pkg::C_BT
         |=> c_q == $past(tbit_q) && $stable(z_q);
   endproperty
   a_bt_carry: assert property (p_bt_carry)
      else $error("tested bit not in carry");

   property p_bit_write;
      s_bit_go |-> (!ds_we) [*3] ##1 (ds_we && last)
                   ##1 ($stable(z_q) && $stable(c_q));
   endproperty
   a_bit_write: assert property (p_bit_write)
      else $error("bit set/clear timing wrong");

   property p_ctrl_len;
      start && (cls == branch_bit_pkg::C_NOP || cls == branch_bit_pkg::C_RET ||
                cls == branch_bit_pkg::C_WAIT) |-> ##1 last ##1 $stable(c_q);
   endproperty
   a_ctrl_len: assert property (p_ctrl_len)
      else $error("control op length or flags wrong");

   property p_stop_wd;
      start && cls == branch_bit_pkg::C_STOP && wd_q
         |-> ##1 (wait_req && !stop_req);
   endproperty
   a_stop_wd: assert property (p_stop_wd)
      else $error("stop not replaced by wait");

   property p_long;
      start && (cls == branch_bit_pkg::C_LONG || cls == branch_bit_pkg::C_CALL)
         |-> ##3 last ##1 (pc_q == {op_q[7:4], b1_q});
   endproperty
   a_long: assert property (p_long)
      else $error("long jump target or length wrong");

   property p_nop;
      start && prog_data == branch_bit_pkg::OP_NOP |-> cls == branch_bit_pkg::C_NOP;
   endproperty
   a_nop: assert property (p_nop)
      else $error("opcode 04 not no-op");

endmodule // branch_bit_control_decoder

// >>> design/branch_bit_pkg.sv
/*
 Constants, opcode classes and state codes for the branch, bit and control
 decoder. Assumes an 8-bit core with a 12-bit program counter and a
 256-byte data space.
*/
package branch_bit_pkg;

   // ----------------------------------------------------------------
   // cycle counts per instruction group
   // ----------------------------------------------------------------
   localparam logic [2:0] CYC_SHORT = 3'h2;
   localparam logic [2:0] CYC_BT = 3'h5;
   localparam logic [2:0] CYC_BIT = 3'h4;
   localparam logic [2:0] CYC_CTRL = 3'h2;
   localparam logic [2:0] CYC_LONG = 3'h4;
   localparam logic [2:0] CYC_OTHER = 3'h1;

   // ----------------------------------------------------------------
   // opcode low nibbles and whole control opcodes
   // ----------------------------------------------------------------
   localparam logic [3:0] LO_JUMP_IF_NONZERO = 4'h0;
   localparam logic [3:0] LO_CALL = 4'h1;
   localparam logic [3:0] LO_JUMP_IF_NO_CARRY = 4'h2;
   localparam logic [3:0] LO_BT = 4'h3;
   localparam logic [3:0] LO_JRZ = 4'h4;
   localparam logic [3:0] LO_JRC = 4'h6;
   localparam logic [3:0] LO_JP = 4'h9;
   localparam logic [3:0] LO_BIT = 4'hB;
   localparam logic [7:0] OP_NOP = 8'h04;
   localparam logic [7:0] OP_RET = 8'h05;
   localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h25;
   localparam logic [7:0] OP_STOP = 8'h45;
   localparam logic [7:0] OP_WAIT = 8'h65;

   // ----------------------------------------------------------------
   // address steps and return stack
   // ----------------------------------------------------------------
   localparam logic [11:0] STEP_1 = 12'h001;
   localparam logic [11:0] STEP_2 = 12'h002;
   localparam logic [11:0] STEP_3 = 12'h003;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam int STACK_DEPTH = 4;

   typedef enum logic [3:0] {
      C_SHORT, C_BT, C_BIT, C_LONG, C_CALL, C_NOP,
      C_RET, C_INTERRUPT_RETURN, C_STOP, C_WAIT, C_OTHER
   } op_class_e;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_OTHER = 3'b100
   } state_e;

endpackage

// >>> design/opcode_classify.sv
/*
 Combinational opcode classifier: group, cycle count and bit position.
 Assumes the opcode byte is stable while it is looked at.
*/
`timescale 1ns/1ps
module opcode_classify (
   input wire logic [7:0] opcode,
   output branch_bit_pkg::op_class_e cls,
   output logic [2:0] ncyc,
   output logic [2:0] bit_idx
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // whole control opcodes first, since 04 sits in a jump column
   // short jumps ignore nibble bit 3: it is the displacement's low bit
   always_comb begin
      cls = branch_bit_pkg::C_OTHER;
      ncyc = branch_bit_pkg::CYC_OTHER;
      if (opcode == branch_bit_pkg::OP_NOP) begin
         cls = branch_bit_pkg::C_NOP;
         ncyc = branch_bit_pkg::CYC_CTRL;
      end else if (opcode == branch_bit_pkg::OP_RET) begin
         cls = branch_bit_pkg::C_RET;
         ncyc = branch_bit_pkg::CYC_CTRL;
      end else if (opcode == branch_bit_pkg::OP_INTERRUPT_RETURN) begin
         cls = branch_bit_pkg::C_INTERRUPT_RETURN;
         ncyc = branch_bit_pkg::CYC_CTRL;
      end else if (opcode == branch_bit_pkg::OP_STOP) begin
         cls = branch_bit_pkg::C_STOP;
         ncyc = branch_bit_pkg::CYC_CTRL;
      end else if (opcode == branch_bit_pkg::OP_WAIT) begin
         cls = branch_bit_pkg::C_WAIT;
         ncyc = branch_bit_pkg::CYC_CTRL;
      end else if ({1'b0, opcode[2:0]} == branch_bit_pkg::LO_JUMP_IF_NONZERO ||
                   {1'b0, opcode[2:0]} == branch_bit_pkg::LO_JUMP_IF_NO_CARRY ||
                   {1'b0, opcode[2:0]} == branch_bit_pkg::LO_JRZ ||
                   {1'b0, opcode[2:0]} == branch_bit_pkg::LO_JRC) begin
         cls = branch_bit_pkg::C_SHORT;
         ncyc = branch_bit_pkg::CYC_SHORT;
      end else if (opcode[3:0] == branch_bit_pkg::LO_CALL) begin
         cls = branch_bit_pkg::C_CALL;
         ncyc = branch_bit_pkg::CYC_LONG;
      end else if (opcode[3:0] == branch_bit_pkg::LO_JP) begin
         cls = branch_bit_pkg::C_LONG;
         ncyc = branch_bit_pkg::CYC_LONG;
      end else if (opcode[3:0] == branch_bit_pkg::LO_BT) begin
         cls = branch_bit_pkg::C_BT;
         ncyc = branch_bit_pkg::CYC_BT;
      end else if (opcode[3:0] == branch_bit_pkg::LO_BIT) begin
         cls = branch_bit_pkg::C_BIT;
         ncyc = branch_bit_pkg::CYC_BIT;
      end
   end

   // bit position sits reversed in the top three opcode bits
   assign bit_idx = {opcode[5], opcode[6], opcode[7]};

endmodule // opcode_classify

// >>> design/bit_unit.sv
/*
 Combinational bit set, clear and test on one data byte.
 Assumes the byte and bit position are valid in the same cycle.
*/
`timescale 1ns/1ps
module bit_unit (
   input wire logic [7:0] byte_in,
   input wire logic [2:0] bit_idx,
   input wire logic set_bit,
   output logic [7:0] byte_out,
   output logic bit_val
);

   // ----------------------------------------------------------------
   // per-bit modify
   // ----------------------------------------------------------------
   // only the selected bit changes; the rest pass as read
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign byte_out[i] = (bit_idx == 3'(i)) ? set_bit : byte_in[i];
   end

   assign bit_val = byte_in[bit_idx];

endmodule // bit_unit

// >>> verif/core_memory_model.sv
/*
 Behavioural program memory and data space that sit around the decoder.
 Assumes one clock; the bench preloads both arrays through the hierarchy.
*/
`timescale 1ns/1ps
module core_memory_model (
   input wire logic clk,
   input wire logic [11:0] prog_addr,
   output logic [7:0] prog_data,
   input wire logic [7:0] ds_addr,
   output logic [7:0] ds_rdata,
   input wire logic [7:0] ds_wdata,
   input wire logic ds_we
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0] prog_mem [0:4095];
   logic [7:0] data_mem [0:255];

   // both reads answer in the same cycle, as the core expects
   assign prog_data = prog_mem[prog_addr];
   assign ds_rdata = data_mem[ds_addr];

   // plain always: the bench also writes these arrays when preloading
   always @(posedge clk) begin
      if (ds_we) begin
         data_mem[ds_addr] <= ds_wdata;
      end
   end
endmodule // core_memory_model

// >>> verif/branch_bit_control_decoder_tb.sv
/*
 Self-checking bench for the branch, bit and control decoder.
 Assumes the memory model answers combinationally; inputs move 1 ns after
 each rising edge.
*/
`timescale 1ns/1ps
module branch_bit_control_decoder_tb;
   localparam time T_HALF = 10ns;
   localparam time T_DRV = 1ns;

   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] prog_addr;
   logic [7:0] prog_data;
   logic [7:0] ds_addr;
   logic [7:0] ds_rdata;
   logic [7:0] ds_wdata;
   logic ds_we;
   logic watchdog_pin = 1'b0;
   logic saved_z = 1'b1;
   logic saved_c = 1'b1;
   logic wake = 1'b0;
   logic other_op;
   logic other_done = 1'b0;
   logic [11:0] other_pc = 12'h000;
   logic stop_req, wait_req, instr_done, flag_z, flag_c;
   logic [11:0] pc;
   logic [11:0] cur;
   logic seen_stop, seen_wait;
   int failures = 0;
   int total_checks = 0;

   branch_bit_control_decoder branch_bit_control_decoder_inst (
      .clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data),
      .ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we),
      .watchdog_pin(watchdog_pin), .saved_z(saved_z), .saved_c(saved_c), .wake(wake),
      .other_op(other_op), .other_done(other_done), .other_pc(other_pc),
      .stop_req(stop_req), .wait_req(wait_req), .instr_done(instr_done),
      .flag_z(flag_z), .flag_c(flag_c), .pc(pc)
   );

   core_memory_model core_memory_model_inst (
      .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .ds_addr(ds_addr),
      .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we)
   );

   // free-running 50 MHz clock
   always #T_HALF clk = ~clk;

   // ------------------------------------------------------------
   // compare, encode and load helpers
   // ------------------------------------------------------------
   task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_cnt(input int got, input int exp, input string what);
      total_checks++;
      if (got != exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   // short jump: displacement in the top five bits
   function automatic logic [7:0] sj(input logic [2:0] lo, input int e);
      return {e[4:0], lo};
   endfunction

   // bit ops: bit number sits reversed in the top three bits
   function automatic logic [7:0] bop(input int b, input logic h, input logic [3:0] lo);
      return {b[0], b[1], b[2], h, lo};
   endfunction

   // fill with no-ops so a stray fetch never runs into unknown bytes
   task automatic clear_prog();
      for (int a = 0; a < 4096; a++) begin
         core_memory_model_inst.prog_mem[a] = branch_bit_pkg::OP_NOP;
      end
   endtask

   task automatic emit(input logic [7:0] b);
      core_memory_model_inst.prog_mem[cur] = b;
      cur = cur + 12'h001;
   endtask

   // ------------------------------------------------------------
   // sequencing helpers
   // ------------------------------------------------------------
   task automatic restart();
      sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      #T_DRV;
      sys_rst = 1'b0;
      cmp_val(pc, 12'h000, "pc after reset");
      cmp_val({flag_z, flag_c}, 2'b00, "flags after reset");
   endtask

   // bounded wait for the last cycle; counts cycles from cycle 0
   task automatic wait_done(output int n);
      n = 1;
      while (instr_done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #T_DRV;
         n++;
      end
      seen_stop = stop_req;
      seen_wait = wait_req;
   endtask

   task automatic step(input int cyc, input logic [11:0] exp_pc, input logic z, input logic c);
      int n;
      wait_done(n);
      cmp_cnt(n, cyc, "cycle count");
      @(posedge clk);
      #T_DRV;
      cmp_val(pc, exp_pc, "next pc");
      cmp_val({flag_z, flag_c}, {z, c}, "flags");
   endtask

   // stop or wait, stay asleep, wake, then run the no-op that follows
   task automatic sleep_wake(input logic s, input logic w, input logic [11:0] exp_pc);
      int n;
      wait_done(n);
      cmp_cnt(n, 2, "control cycles");
      cmp_val(seen_stop, s, "stop request");
      cmp_val(seen_wait, w, "wait request");
      repeat (4) @(posedge clk);
      #T_DRV;
      cmp_val(instr_done, 1'b0, "asleep");
      wake = 1'b1;
      @(posedge clk);
      #T_DRV;
      wake = 1'b0;
      wait_done(n);
      @(posedge clk);
      #T_DRV;
      cmp_val(pc, exp_pc, "pc after wake");
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_short_jumps();
      clear_prog();
      cur = 12'h000;
      emit(sj(3'h0, 15));
      cur = 12'h010;
      emit(sj(3'h4, -16));
      emit(sj(3'h2, 15));
      cur = 12'h015;
      emit(sj(3'h6, 15));
      cur = 12'h021;
      emit(sj(3'h6, 3));
      emit(8'h31);
      emit(8'h00);
      emit(sj(3'h4, -16));
      emit(sj(3'h0, 1));
      emit(sj(3'h2, 1));
      emit(8'hA9);
      emit(8'hBC);
      cur = 12'h300;
      emit(branch_bit_pkg::OP_INTERRUPT_RETURN);
      restart();
      step(2, 12'h010, 1'b0, 1'b0);
      step(2, 12'h011, 1'b0, 1'b0);
      step(2, 12'h021, 1'b0, 1'b0);
      step(2, 12'h022, 1'b0, 1'b0);
      step(4, 12'h300, 1'b0, 1'b0);
      step(2, 12'h024, 1'b1, 1'b1);
      step(2, 12'h015, 1'b1, 1'b1);
      step(2, 12'h025, 1'b1, 1'b1);
      step(2, 12'h026, 1'b1, 1'b1);
      step(2, 12'h027, 1'b1, 1'b1);
      step(4, 12'hABC, 1'b1, 1'b1);
      $display("short jump and long jump test done");
   endtask

   task automatic test_bit_ops();
      logic [11:0] p;
      logic [7:0] exp_set;
      logic [7:0] exp_clr;
      clear_prog();
      // plain ram bytes only, never port registers
      core_memory_model_inst.data_mem[8'h40] = 8'h00;
      core_memory_model_inst.data_mem[8'h41] = 8'hFF;
      cur = 12'h000;
      for (int b = 0; b < 8; b++) begin
         emit(bop(b, 1'b1, 4'hB));
         emit(8'h40);
         emit(bop(b, 1'b0, 4'hB));
         emit(8'h41);
      end
      emit(bop(7, 1'b1, 4'h3));
      emit(8'h40);
      emit(8'h7F);
      cur = 12'h026;
      emit(bop(0, 1'b1, 4'h3));
      emit(8'h41);
      emit(8'h10);
      cur = 12'h0A1;
      emit(bop(3, 1'b0, 4'h3));
      emit(8'h40);
      emit(8'h80);
      emit(bop(5, 1'b0, 4'h3));
      emit(8'h41);
      emit(8'h80);
      restart();
      p = 12'h000;
      exp_set = 8'h00;
      exp_clr = 8'hFF;
      for (int b = 0; b < 8; b++) begin
         p = p + 12'h002;
         step(4, p, 1'b0, 1'b0);
         exp_set[b] = 1'b1;
         cmp_val(core_memory_model_inst.data_mem[8'h40], exp_set, "set byte");
         p = p + 12'h002;
         step(4, p, 1'b0, 1'b0);
         exp_clr[b] = 1'b0;
         cmp_val(core_memory_model_inst.data_mem[8'h41], exp_clr, "clear byte");
      end
      step(5, 12'h0A1, 1'b0, 1'b1);
      step(5, 12'h0A4, 1'b0, 1'b1);
      step(5, 12'h026, 1'b0, 1'b0);
      step(5, 12'h029, 1'b0, 1'b0);
      $display("bit set, clear and test test done");
   endtask

   task automatic test_control();
      clear_prog();
      cur = 12'h001;
      emit(branch_bit_pkg::OP_STOP);
      cur = 12'h003;
      emit(branch_bit_pkg::OP_WAIT);
      cur = 12'h005;
      emit(branch_bit_pkg::OP_STOP);
      cur = 12'h007;
      emit(8'h21);
      emit(8'h00);
      emit(8'h0D);
      cur = 12'h200;
      emit(branch_bit_pkg::OP_RET);
      watchdog_pin = 1'b0;
      restart();
      step(2, 12'h001, 1'b0, 1'b0);
      sleep_wake(1'b1, 1'b0, 12'h003);
      watchdog_pin = 1'b1;
      sleep_wake(1'b0, 1'b1, 12'h005);
      sleep_wake(1'b0, 1'b1, 12'h007);
      step(4, 12'h200, 1'b0, 1'b0);
      step(2, 12'h009, 1'b0, 1'b0);
      // foreign opcode handed to the core, which resumes elsewhere
      cmp_val(other_op, 1'b1, "foreign opcode flagged");
      @(posedge clk);
      #T_DRV;
      other_done = 1'b1;
      other_pc = 12'h123;
      @(posedge clk);
      #T_DRV;
      other_done = 1'b0;
      step(2, 12'h124, 1'b0, 1'b0);
      $display("control and handoff test done");
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end
      else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      test_short_jumps();
      test_bit_ops();
      test_control();
      tally_and_finish();
   end

   // all tests need under two hundred cycles; 5000 leaves wide margin for a hang
   initial begin
      #(T_HALF * 2 * 5000);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule // branch_bit_control_decoder_tb
